// *** irta_rate_table_access.sv ***
// Contract
// - Command register write launches the table access.
// - Command bit 7: one reads, zero writes.
// - Bits 6:5 select rate, committed, excess burst.
// - Bits 4:0 index one of 24 rate entries.
// - Port-and-priority mode: eight entries per port.
// - Port-only mode: entry index equals port number.
// - Priority-only mode: entry index equals priority.
// - Table holds 24 rates plus two bursts, 16-bit.
// - Excess burst limit resets to 0600h.
// - Committed burst limit resets to 0600h.
// - Excess buckets start at the default burst value.
// - Byte time is (entry plus one) times 20 ns.
// - Pending flag holds during access, clears after.
// - Write value bits 15:0 stored on write command.
// - Read value shows entry of latest read command.
// - Mode 00 port+prio, 01 port, 10 prio.
`timescale 1ns/10ps
`default_nettype none
module irta_rate_table_access (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  lookup_port,
    input  wire logic [4:0]  lookup_prio,
    output logic             meter_enable,
    output logic [1:0]       metering_mode,
    output logic [15:0]      committed_rate_value,
    output logic [17:0]      byte_time_cycles,
    output logic [15:0]      committed_burst_limit,
    output logic [15:0]      excess_burst_limit,
    output logic [15:0]      excess_bucket_init
);
    irta_tbl_if tbl ();

    irta_table_store u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tbl     (tbl)
    );

    // Bus slave state.
    logic        aw_full_q, aw_full_d;
    logic        w_full_q, w_full_d;
    logic [15:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    // Register state.
    logic [2:0]  cfg_q, cfg_d;
    logic [7:0]  cmd_q, cmd_d;
    logic        pend_q, pend_d;
    logic [15:0] wrval_q, wrval_d;
    logic [15:0] rdval_q, rdval_d;
    logic        req_q, req_d;
    logic        dir_q, dir_d;
    logic [4:0]  slot_q, slot_d;
    logic        slot_ok_q, slot_ok_d;
    // Lookup pipeline state.
    logic [4:0]  look_idx_q, look_idx_d;
    logic [15:0] rate_q, rate_d;
    logic [17:0] btime_q, btime_d;
    logic [15:0] cbs_q, cbs_d;
    logic [15:0] ebs_q, ebs_d;
    logic        do_write;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Byte lanes merge the incoming word over the current register contents.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Read decode; unmapped addresses answer with an error and zero data.
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            irta_pkg::CFG_ADDR:   rd_word = {29'h0000_0000, cfg_q};
            irta_pkg::CMD_ADDR:   rd_word = {24'h00_0000, cmd_q};
            irta_pkg::STS_ADDR:   rd_word = {31'h0000_0000, pend_q};
            irta_pkg::WRVAL_ADDR: rd_word = {16'h0000, wrval_q};
            irta_pkg::RDVAL_ADDR: rd_word = {16'h0000, rdval_q};
            default:              rd_hit  = 1'b0;
        endcase
    end

    // Write channels are taken in either order and held until both are present.
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        do_write  = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid_q) begin
            do_write  = 1'b1;
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            unique case (awaddr_q)
                irta_pkg::CFG_ADDR, irta_pkg::CMD_ADDR, irta_pkg::STS_ADDR,
                irta_pkg::WRVAL_ADDR, irta_pkg::RDVAL_ADDR: bresp_d = irta_pkg::RESP_OKAY;
                default: bresp_d = irta_pkg::RESP_SLVERR;
            endcase
        end
        // Readies drop while a channel is held so one write at a time is in flight.
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
    end

    // Read channel answers one cycle after the address is taken.
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_word;
            rresp_d  = rd_hit ? irta_pkg::RESP_OKAY : irta_pkg::RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    // Register writes and command launch.
    always_comb begin
        cfg_d     = cfg_q;
        cmd_d     = cmd_q;
        pend_d    = pend_q;
        wrval_d   = wrval_q;
        rdval_d   = rdval_q;
        req_d     = 1'b0;
        dir_d     = dir_q;
        slot_d    = slot_q;
        slot_ok_d = slot_ok_q;
        // A finished access clears pending; a read also latches its result.
        if (tbl.done) begin
            pend_d = 1'b0;
            if (dir_q) begin
                rdval_d = tbl.rdata;
            end
        end
        if (do_write) begin
            unique case (awaddr_q)
                irta_pkg::CFG_ADDR: begin
                    cfg_d = 3'(lane_merge({29'h0000_0000, cfg_q}, wdata_q, wstrb_q));
                end
                irta_pkg::WRVAL_ADDR: begin
                    wrval_d = 16'(lane_merge({16'h0000, wrval_q}, wdata_q, wstrb_q));
                end
                irta_pkg::CMD_ADDR: begin
                    // Busy writes are dropped so the running access is not corrupted.
                    if (!pend_q) begin
                        cmd_d  = 8'(lane_merge({24'h00_0000, cmd_q}, wdata_q, wstrb_q));
                        pend_d = 1'b1;
                        req_d  = 1'b1;
                        dir_d  = cmd_d[irta_pkg::CMD_DIR_BIT];
                        slot_ok_d = 1'b1;
                        slot_d = cmd_d[irta_pkg::CMD_INDEX_HI:irta_pkg::CMD_INDEX_LO];
                        unique case (cmd_d[irta_pkg::CMD_TYPE_HI:irta_pkg::CMD_TYPE_LO])
                            irta_pkg::TYPE_CIR: begin
                                slot_ok_d = slot_d < 5'(irta_pkg::NUM_CIR);
                            end
                            irta_pkg::TYPE_CBS: slot_d = irta_pkg::SLOT_CBS;
                            irta_pkg::TYPE_EBS: slot_d = irta_pkg::SLOT_EBS;
                            irta_pkg::TYPE_RSVD: slot_ok_d = 1'b0;
                        endcase
                    end
                end
                default: begin
                    cfg_d = cfg_q;
                end
            endcase
        end
    end

    // Rate entry chosen per metering mode from the packet's port and priority.
    always_comb begin
        unique case (cfg_q[irta_pkg::CFG_MODE_HI:irta_pkg::CFG_MODE_LO])
            irta_pkg::MODE_PORT_PRIO: begin
                look_idx_d = 5'(lookup_port * irta_pkg::PORT_STRIDE) + {2'b00, lookup_prio[2:0]};
            end
            irta_pkg::MODE_PORT_ONLY: look_idx_d = {3'b000, lookup_port};
            irta_pkg::MODE_PRIO_ONLY: look_idx_d = lookup_prio;
            default:                  look_idx_d = look_idx_q;
        endcase
        rate_d  = tbl.lookup_rate;
        // Each unit of 20 ns is two clock cycles at the 100 MHz rate.
        btime_d = 18'(({2'b00, tbl.lookup_rate} + 18'd1) * 18'(irta_pkg::CYCLES_PER_UNIT));
        cbs_d   = tbl.cbs;
        ebs_d   = tbl.ebs;
    end

    // All state registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q  <= 1'b0;
            w_full_q   <= 1'b0;
            awaddr_q   <= 16'h0000;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= irta_pkg::RESP_OKAY;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= irta_pkg::RESP_OKAY;
            cfg_q      <= 3'h0;
            cmd_q      <= irta_pkg::CMD_RESET;
            pend_q     <= 1'b0;
            wrval_q    <= irta_pkg::WRVAL_RESET;
            rdval_q    <= 16'h0000;
            req_q      <= 1'b0;
            dir_q      <= 1'b0;
            slot_q     <= 5'h00;
            slot_ok_q  <= 1'b0;
            look_idx_q <= 5'h00;
            rate_q     <= irta_pkg::CIR_RESET;
            btime_q    <= 18'h0_0000;
            cbs_q      <= irta_pkg::CBS_RESET;
            ebs_q      <= irta_pkg::EBS_RESET;
        end else begin
            aw_full_q  <= aw_full_d;
            w_full_q   <= w_full_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            cfg_q      <= cfg_d;
            cmd_q      <= cmd_d;
            pend_q     <= pend_d;
            wrval_q    <= wrval_d;
            rdval_q    <= rdval_d;
            req_q      <= req_d;
            dir_q      <= dir_d;
            slot_q     <= slot_d;
            slot_ok_q  <= slot_ok_d;
            look_idx_q <= look_idx_d;
            rate_q     <= rate_d;
            btime_q    <= btime_d;
            cbs_q      <= cbs_d;
            ebs_q      <= ebs_d;
        end
    end

    assign tbl.req        = req_q;
    assign tbl.write      = !dir_q;
    assign tbl.slot       = slot_q;
    assign tbl.slot_ok    = slot_ok_q;
    assign tbl.wdata      = wrval_q;
    assign tbl.lookup_idx = look_idx_q;

    // Outputs, each straight from a flip-flop except excess_bucket_init, which is the constant EBS_RESET.
    assign s_axi_awready         = awready_q;
    assign s_axi_wready          = wready_q;
    assign s_axi_bvalid          = bvalid_q;
    assign s_axi_bresp           = bresp_q;
    assign s_axi_arready         = arready_q;
    assign s_axi_rvalid          = rvalid_q;
    assign s_axi_rdata           = rdata_q;
    assign s_axi_rresp           = rresp_q;
    assign meter_enable          = cfg_q[irta_pkg::CFG_EN_BIT];
    assign metering_mode         = cfg_q[irta_pkg::CFG_MODE_HI:irta_pkg::CFG_MODE_LO];
    assign committed_rate_value  = rate_q;
    assign byte_time_cycles      = btime_q;
    assign committed_burst_limit = cbs_q;
    assign excess_burst_limit    = ebs_q;
    assign excess_bucket_init    = irta_pkg::EBS_RESET;
endmodule
`default_nettype wire

// *** irta_pkg.sv ***
// Shared constants for the ingress rate table access block.
package irta_pkg;

    // Printed register numbers are word indices; byte address is four times the index.
    localparam logic [15:0] CFG_IDX    = 16'h184A;
    localparam logic [15:0] CMD_IDX    = 16'h184B;
    localparam logic [15:0] STS_IDX    = 16'h184C;
    localparam logic [15:0] WRVAL_IDX  = 16'h184D;
    localparam logic [15:0] RDVAL_IDX  = 16'h184E;
    localparam logic [15:0] CFG_ADDR   = 16'(CFG_IDX * 4);
    localparam logic [15:0] CMD_ADDR   = 16'(CMD_IDX * 4);
    localparam logic [15:0] STS_ADDR   = 16'(STS_IDX * 4);
    localparam logic [15:0] WRVAL_ADDR = 16'(WRVAL_IDX * 4);
    localparam logic [15:0] RDVAL_ADDR = 16'(RDVAL_IDX * 4);

    // Command register fields.
    localparam int CMD_DIR_BIT  = 7;
    localparam int CMD_TYPE_HI  = 6;
    localparam int CMD_TYPE_LO  = 5;
    localparam int CMD_INDEX_HI = 4;
    localparam int CMD_INDEX_LO = 0;
    localparam logic [7:0] CMD_RESET = 8'h00;

    // Entry type encodings.
    localparam logic [1:0] TYPE_RSVD = 2'b00;
    localparam logic [1:0] TYPE_CIR  = 2'b01;
    localparam logic [1:0] TYPE_CBS  = 2'b10;
    localparam logic [1:0] TYPE_EBS  = 2'b11;

    // Metering config fields and mode encodings.
    localparam int CFG_EN_BIT  = 0;
    localparam int CFG_MODE_HI = 2;
    localparam int CFG_MODE_LO = 1;
    localparam logic [1:0] MODE_PORT_PRIO = 2'b00;
    localparam logic [1:0] MODE_PORT_ONLY = 2'b01;
    localparam logic [1:0] MODE_PRIO_ONLY = 2'b10;

    // Table layout: committed rate entries first, then the two burst sizes.
    localparam int          NUM_CIR   = 24;
    localparam int          NUM_SLOTS = 26;
    localparam logic [4:0]  SLOT_CBS  = 5'd24;
    localparam logic [4:0]  SLOT_EBS  = 5'd25;
    localparam logic [4:0]  PORT_STRIDE = 5'd8;
    localparam logic [15:0] CIR_RESET = 16'h0014;
    localparam logic [15:0] CBS_RESET = 16'h0600;
    localparam logic [15:0] EBS_RESET = 16'h0600;
    localparam logic [15:0] WRVAL_RESET = 16'h0000;

    // Byte time is (entry + 1) units of 20 ns.
    localparam int BYTE_UNIT_NS    = 20;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CYCLES_PER_UNIT = BYTE_UNIT_NS / CLK_PERIOD_NS;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** irta_tbl_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Carrier between the register front end and the table store.
interface irta_tbl_if;
    logic        req;
    logic        write;
    logic [4:0]  slot;
    logic        slot_ok;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    logic [4:0]  lookup_idx;
    logic [15:0] lookup_rate;
    logic [15:0] cbs;
    logic [15:0] ebs;

    modport front (output req, write, slot, slot_ok, wdata, lookup_idx,
                   input done, rdata, lookup_rate, cbs, ebs);
    modport store (input req, write, slot, slot_ok, wdata, lookup_idx,
                   output done, rdata, lookup_rate, cbs, ebs);
endinterface
`default_nettype wire

// *** irta_table_store.sv ***
`timescale 1ns/10ps
`default_nettype none
// Holds the 24 committed rate entries and both burst sizes.
module irta_table_store (
    input  wire logic aclk,
    input  wire logic aresetn,
    irta_tbl_if.store tbl
);
    logic [15:0] mem_q [irta_pkg::NUM_SLOTS];
    logic [15:0] mem_d [irta_pkg::NUM_SLOTS];
    logic        done_q;
    logic        done_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [15:0] look_q;
    logic [15:0] look_d;

    // Access one slot per request; invalid slots complete without a write and read as zero.
    always_comb begin
        mem_d   = mem_q;
        done_d  = tbl.req;
        rdata_d = rdata_q;
        if (tbl.req) begin
            if (!tbl.slot_ok) begin
                rdata_d = 16'h0000;
            end else if (tbl.write) begin
                mem_d[tbl.slot] = tbl.wdata;
            end else begin
                rdata_d = mem_q[tbl.slot];
            end
        end
        // Lookup index beyond the table is undefined by software contract.
        if (tbl.lookup_idx < 5'(irta_pkg::NUM_CIR)) begin
            look_d = mem_q[tbl.lookup_idx];
        end else begin
            look_d = 16'h0000;
        end
    end

    // Entries come out of reset at their documented defaults.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < irta_pkg::NUM_CIR; i++) begin
                mem_q[i] <= irta_pkg::CIR_RESET;
            end
            mem_q[irta_pkg::SLOT_CBS] <= irta_pkg::CBS_RESET;
            mem_q[irta_pkg::SLOT_EBS] <= irta_pkg::EBS_RESET;
            done_q  <= 1'b0;
            rdata_q <= 16'h0000;
            look_q  <= 16'h0000;
        end else begin
            mem_q   <= mem_d;
            done_q  <= done_d;
            rdata_q <= rdata_d;
            look_q  <= look_d;
        end
    end

    assign tbl.done        = done_q;
    assign tbl.rdata       = rdata_q;
    assign tbl.lookup_rate = look_q;
    assign tbl.cbs         = mem_q[irta_pkg::SLOT_CBS];
    assign tbl.ebs         = mem_q[irta_pkg::SLOT_EBS];
endmodule
`default_nettype wire

// *** irta_rate_table_access_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the register bus and the metering outputs.
module irta_rate_table_access_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  metering_mode,
    input wire logic [15:0] committed_rate_value,
    input wire logic [17:0] byte_time_cycles,
    input wire logic [15:0] committed_burst_limit,
    input wire logic [15:0] excess_burst_limit,
    input wire logic [15:0] excess_bucket_init
);
    logic [3:0] wr_age_q;
    logic [3:0] wr_age_d;

    // Cycles since a write address was taken; it saturates so a long idle never wraps.
    always_comb begin
        wr_age_d = (wr_age_q == 4'hF) ? wr_age_q : wr_age_q + 4'h1;
        if (s_axi_awvalid && s_axi_awready) begin
            wr_age_d = 4'h0;
        end
    end

    // Reset counts as recent so the first compare after release cannot misfire.
    always_ff @(posedge aclk) begin
        wr_age_q <= aresetn ? wr_age_d : 4'h0;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response did not follow the taken write");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late after the taken address");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    byte_time_a: assert property (
        $past(aresetn, 4) |-> byte_time_cycles == ({2'b00, committed_rate_value} + 18'h1) << 1)
        else $error("byte time does not match the rate entry");
    bucket_init_a: assert property (
        excess_bucket_init == 16'h0600)
        else $error("excess bucket start value is wrong");
    burst_cause_a: assert property (
        !$stable(committed_burst_limit) || !$stable(excess_burst_limit) |-> wr_age_q <= 4'd8)
        else $error("burst limit changed without a register write");
    mode_cause_a: assert property (
        !$stable(metering_mode) |-> wr_age_q <= 4'd4)
        else $error("metering mode changed without a register write");
endmodule

bind irta_rate_table_access irta_rate_table_access_sva irta_rate_table_access_sva_inst (.*);
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// Register traffic and packet lookups compared against a behavioural table model.
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, metering_mode;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        meter_enable;
    logic [1:0]  lookup_port = 2'b00;
    logic [4:0]  lookup_prio = 5'h00;
    logic [15:0] committed_rate_value, committed_burst_limit, excess_burst_limit;
    logic [15:0] excess_bucket_init;
    logic [17:0] byte_time_cycles;
    int          num_errors = 0;
    int          num_checks = 0;
    int          b_lag;
    int          mdl[26];
    int          wv;

    irta_rate_table_access irta_rate_table_access_inst (.*);

    // Free-running 100 MHz clock.
    always #5 aclk = ~aclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Response ready is raised after a random stall so the slave must hold its answer.
    task automatic axi_write(input logic [15:0] addr, input logic [31:0] data,
                             output logic [1:0] resp);
        b_lag = 0;
        s_axi_awaddr  <= addr;
        s_axi_wdata   <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) b_lag++;
            if (!s_axi_awvalid && !s_axi_wvalid && !s_axi_bready && $urandom_range(2) == 0)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [15:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_arvalid && !s_axi_rready && $urandom_range(2) == 0)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_wv(input logic [15:0] v);
        logic [1:0] r;
        axi_write(irta_pkg::WRVAL_ADDR, {16'h0, v}, r);
        wv = int'(v);
    endtask

    // One indirect access: command, poll the pending flag, then fetch or update the model.
    task automatic run_cmd(input logic rd, input logic [1:0] typ, input logic [4:0] idx);
        logic [1:0]  r;
        logic [31:0] d;
        int          slot;
        int          n;
        slot = (typ == 2'b01) ? int'(idx) : (typ == 2'b10) ? 24 : (typ == 2'b11) ? 25 : -1;
        axi_write(irta_pkg::CMD_ADDR, {24'h0, rd, typ, idx}, r);
        check("cmd_resp", r, irta_pkg::RESP_OKAY);
        n = b_lag;
        do begin
            axi_read(irta_pkg::STS_ADDR, d, r);
            if (n == 0) check("pending_set", d, 32'h1);
            n++;
        end while (d[0] !== 1'b0 && n < 8);
        check("pending_clear", d, 32'h0);
        if (rd) begin
            axi_read(irta_pkg::RDVAL_ADDR, d, r);
            check("read_value", d, (slot < 0) ? 0 : mdl[slot]);
        end else if (slot >= 0) begin
            mdl[slot] = wv;
        end
    endtask

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [1:0]  typ;
        int          ix;
        int          p;
        int          q;
        foreach (mdl[i]) mdl[i] = (i < 24) ? 32'h0000_0014 : 32'h0000_0600;
        d = $urandom(88);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check("cbs_out", committed_burst_limit, 16'h0600);
        check("ebs_out", excess_burst_limit, 16'h0600);
        check("bucket_init", excess_bucket_init, 16'h0600);
        check("mode_out", {metering_mode, meter_enable}, 3'b000);
        // Pass 0 reads reset contents, pass 1 writes corner and random values, pass 2 reads.
        for (int pass = 0; pass < 3; pass++) begin
            for (int i = 0; i < 26; i++) begin
                typ = (i < 24) ? 2'b01 : (i == 24) ? 2'b10 : 2'b11;
                ix  = (i < 24) ? i : $urandom_range(31);
                p = (i == 23) ? 0 : (i == 0 || i == 25) ? 16'hFFFF : 16'($urandom);
                if (pass == 1) set_wv(16'(p));
                run_cmd(pass != 1, typ, 5'(ix));
            end
            if (pass == 1) begin
                run_cmd(1'b0, 2'b00, 5'd4);
                run_cmd(1'b1, 2'b00, 5'd4);
            end
        end
        check("cbs_out", committed_burst_limit, mdl[24]);
        check("ebs_out", excess_burst_limit, mdl[25]);
        // Lookups in each mode: port 2 with the mode's highest priority first, then random ones.
        for (int m = 0; m < 3; m++) begin
            axi_write(irta_pkg::CFG_ADDR, 32'(m * 2 + 1), r);
            for (int k = 0; k < 8; k++) begin
                p = (k == 0) ? 2 : $urandom_range(2);
                q = (k == 0) ? ((m == 2) ? 23 : 7) : $urandom_range((m == 2) ? 23 : 7);
                lookup_port <= 2'(p);
                lookup_prio <= 5'(q);
                repeat (4) @(posedge aclk);
                ix = (m == 0) ? p * 8 + q : (m == 1) ? p : q;
                check("rate_value", committed_rate_value, mdl[ix]);
                check("byte_time", byte_time_cycles, (mdl[ix] + 1) * 2);
            end
            check("mode_out", {metering_mode, meter_enable}, m * 2 + 1);
        end
        // Reserved mode keeps the last chosen entry whatever the packet says.
        axi_write(irta_pkg::CFG_ADDR, 32'h0000_0007, r);
        lookup_prio <= 5'(q ^ 1);
        repeat (4) @(posedge aclk);
        check("rsvd_mode", committed_rate_value, mdl[q]);
        // Unmapped places answer with an error; a write to the read-only status is ignored.
        axi_write(16'h0000, 32'h0000_00FF, r);
        check("bad_wr_resp", r, irta_pkg::RESP_SLVERR);
        axi_read(16'h0004, d, r);
        check("bad_rd_resp", r, irta_pkg::RESP_SLVERR);
        check("bad_rd_data", d, 32'h0);
        axi_write(irta_pkg::STS_ADDR, 32'h0000_0001, r);
        axi_read(irta_pkg::STS_ADDR, d, r);
        check("status_ro", d, 32'h0);
        print_verdict();
    end

    // The tests need a few thousand cycles; this limit leaves a wide margin for slow answers.
    initial begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
